// ---- verilog/rmii_config_defs.vh ----
`ifndef RMII_CONFIG_DEFS_VH
`define RMII_CONFIG_DEFS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RMII_CONFIG_ADDR      16'hff24
`define RMII_CONFIG_RESET     16'h0116
`define RMII_CONFIG_RSVD_VAL  8'h01

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BUF_CLEAR_BIT         7
`define DEPTH_SEL_MSB         6
`define DEPTH_SEL_LSB         4
`define SOF_WATCH_BIT         3
`define CARRIER_ENC_BIT       2
`define FALSE_CARRIER_BIT     1
`define REDUCED_IF_BIT        0

// ----------------------------------------------------------------
// Depth codes and elastic buffer sizing
// ----------------------------------------------------------------
`define DEPTH_CODE_MAX        3'h5
`define BUF_ADDR_W            5

// ----------------------------------------------------------------
// AHB-Lite encodings
// ----------------------------------------------------------------
`define HTRANS_NONSEQ         2'h2
`define HTRANS_SEQ            2'h3
`define HSIZE_WORD            3'h2
`define HRESP_OKAY            1'b0

`endif

// ---- verilog/rmii_dibit_ram.v ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Dibit store for the receive elastic buffer, registered read
// ----------------------------------------------------------------
module rmii_dibit_ram #(
  parameter AW = 5
) (
  input  wire          hclk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [1:0]    wr_data,
  input  wire          rd_en,
  input  wire [AW-1:0] rd_addr,
  output reg  [1:0]    rd_data_ff
);

  reg [1:0] mem [0:(1<<AW)-1];

  always @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_ff <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

// ---- verilog/tx_sof_watch.v ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Frame start finder on the transmit pins
// ----------------------------------------------------------------
module tx_sof_watch (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       watch_en,
  input  wire       tx_en_s,
  input  wire [1:0] txd_s,
  output reg        tx_active_ff,
  output reg        tx_sof_ff
);

  reg nxt_active;
  reg nxt_sof;

  always @* begin
    nxt_active = tx_active_ff;
    nxt_sof    = 1'b0;
    if (!tx_en_s) begin
      nxt_active = 1'b0;
    end else if (!tx_active_ff) begin
      // With watching on, enable alone is not a frame: wait for preamble
      if (!watch_en || txd_s != 2'h0) begin
        nxt_active = 1'b1;
        nxt_sof    = 1'b1;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_active_ff <= 1'b0;
      tx_sof_ff    <= 1'b0;
    end else begin
      tx_active_ff <= nxt_active;
      tx_sof_ff    <= nxt_sof;
    end
  end

endmodule

`default_nettype wire

// ---- verilog/rmii_mac_port_config.v ----
// Summary of operation
// - Bit 7 of the config register, reset zero, holds the receive elastic buffer in clear.
// - Bits [6:4] pick the buffer depth, codes 000..101 meaning plus or minus 4 to 24 bits.
// - Bit 3 makes the transmit side find frame start from both data lines, not enable alone.
// - Bit 2, reset one, encodes carrier sense into the crs_dv output while bit 7 is clear.
// - Bit 1, reset one, raises rx_er on a false carrier (bad start delimiter).
// - With bit 1 clear, rx_er is raised only for a symbol error inside a frame.
// - Bit 0 selects the reduced interface and takes its power-up value from the strap pin.
`include "rmii_config_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module rmii_mac_port_config #(
  parameter AW = `BUF_ADDR_W
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        strap_reduced_if,
  input  wire        core_rx_en,
  input  wire        core_rx_dv,
  input  wire [1:0]  core_rxd,
  input  wire        core_carrier,
  input  wire        core_sym_err,
  input  wire        core_false_carrier,
  input  wire        mac_tick,
  output reg         crs_dv,
  output reg  [1:0]  rxd,
  output reg         rx_er,
  input  wire        tx_en,
  input  wire [1:0]  txd,
  output reg         tx_frame_start,
  output reg         tx_frame_active,
  output reg         reduced_if_select
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Full register reset value; only the low byte is held in flops
  localparam [15:0] CFG_RESET = `RMII_CONFIG_RESET;

  // Mid-point fill in dibits: half of the plus/minus span
  function [AW:0] fill_mark;
    input [2:0] code;
    reg   [2:0] c;
    begin
      c = (code > `DEPTH_CODE_MAX) ? `DEPTH_CODE_MAX : code;
      fill_mark = {{(AW-2){1'b0}}, c} + {{(AW-2){1'b0}}, 3'h1};
      fill_mark = fill_mark << 1;
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg       strap_m_ff;
  reg       strap_s_ff;
  reg [2:0] tx_m_ff;
  reg [2:0] tx_s_ff;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_m_ff <= 1'b0;
      strap_s_ff <= 1'b0;
      tx_m_ff    <= 3'h0;
      tx_s_ff    <= 3'h0;
    end else begin
      strap_m_ff <= strap_reduced_if;
      strap_s_ff <= strap_m_ff;
      tx_m_ff    <= {tx_en, txd};
      tx_s_ff    <= tx_m_ff;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  reg        wr_pend_ff;
  reg        strap_wait_ff;
  reg [2:0]  strap_cnt_ff;
  reg [7:0]  cfg_ff;
  reg [7:0]  nxt_cfg;
  reg [31:0] nxt_rdata;
  wire       addr_ph;
  wire       hit;

  assign addr_ph = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
  assign hit     = (haddr[15:0] == `RMII_CONFIG_ADDR) && (haddr[31:16] == 16'h0000);

  always @* begin
    nxt_cfg = cfg_ff;
    if (wr_pend_ff) begin
      nxt_cfg = hwdata[7:0];
    end
    if (strap_wait_ff && strap_cnt_ff == 3'h0) begin
      nxt_cfg[`REDUCED_IF_BIT] = strap_s_ff;
    end
    nxt_rdata = 32'h0000_0000;
    if (addr_ph && !hwrite && hit) begin
      nxt_rdata = {16'h0000, `RMII_CONFIG_RSVD_VAL, nxt_cfg};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff        <= CFG_RESET[7:0];
      wr_pend_ff    <= 1'b0;
      strap_wait_ff <= 1'b1;
      strap_cnt_ff  <= 3'h2;
      hrdata        <= 32'h0000_0000;
      hreadyout     <= 1'b1;
      hresp         <= `HRESP_OKAY;
    end else begin
      cfg_ff     <= nxt_cfg;
      wr_pend_ff <= addr_ph && hwrite && hit && (hsize == `HSIZE_WORD);
      hrdata     <= nxt_rdata;
      // Strap is sampled once the synchroniser holds a settled value
      if (strap_wait_ff) begin
        if (strap_cnt_ff == 3'h0) begin
          strap_wait_ff <= 1'b0;
        end else begin
          strap_cnt_ff <= strap_cnt_ff - 3'h1;
        end
      end
    end
  end

  wire       buf_clear;
  wire [2:0] depth_sel;
  wire       sof_watch_en;
  wire       carrier_encode_en;
  wire       false_carrier_err_en;

  assign buf_clear            = cfg_ff[`BUF_CLEAR_BIT];
  assign depth_sel            = cfg_ff[`DEPTH_SEL_MSB:`DEPTH_SEL_LSB];
  assign sof_watch_en         = cfg_ff[`SOF_WATCH_BIT];
  assign carrier_encode_en    = cfg_ff[`CARRIER_ENC_BIT];
  assign false_carrier_err_en = cfg_ff[`FALSE_CARRIER_BIT];

  // ----------------------------------------------------------------
  // Receive elastic buffer
  // ----------------------------------------------------------------
  reg  [AW:0] wr_ptr_ff;
  reg  [AW:0] rd_ptr_ff;
  reg         primed_ff;
  reg         rd_vld_ff;
  wire [AW:0] level;
  wire        full;
  wire        wr_go;
  wire        rd_go;
  wire [1:0]  buf_q;
  wire [1:0]  err_q;

  assign level = wr_ptr_ff - rd_ptr_ff;
  assign full  = level[AW];
  assign wr_go = core_rx_en && core_rx_dv && !full && !buf_clear;
  assign rd_go = mac_tick && primed_ff && (level != {(AW+1){1'b0}}) && !buf_clear;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_ff  <= {(AW+1){1'b0}};
      rd_ptr_ff  <= {(AW+1){1'b0}};
      primed_ff  <= 1'b0;
      rd_vld_ff  <= 1'b0;
    end else if (buf_clear) begin
      // Held dibits are dropped; forwarding restarts from empty
      wr_ptr_ff  <= {(AW+1){1'b0}};
      rd_ptr_ff  <= {(AW+1){1'b0}};
      primed_ff  <= 1'b0;
      rd_vld_ff  <= 1'b0;
    end else begin
      if (wr_go) begin
        wr_ptr_ff <= wr_ptr_ff + {{AW{1'b0}}, 1'b1};
      end
      if (rd_go) begin
        rd_ptr_ff <= rd_ptr_ff + {{AW{1'b0}}, 1'b1};
      end
      if (!primed_ff && level >= fill_mark(depth_sel)) begin
        primed_ff <= 1'b1;
      end else if (primed_ff && !core_rx_dv && level == {(AW+1){1'b0}}) begin
        primed_ff <= 1'b0;
      end
      if (mac_tick) begin
        rd_vld_ff <= rd_go;
      end
    end
  end

  rmii_dibit_ram #(
    .AW (AW)
  ) u_ram (
    .hclk       (hclk),
    .wr_en      (wr_go),
    .wr_addr    (wr_ptr_ff[AW-1:0]),
    .wr_data    (core_rxd),
    .rd_en      (rd_go),
    .rd_addr    (rd_ptr_ff[AW-1:0]),
    .rd_data_ff (buf_q)
  );

  // Symbol error flag travels beside its own dibit, so it leaves with it.
  // The flag fills both bits of the store's word.
  rmii_dibit_ram #(
    .AW (AW)
  ) u_err_ram (
    .hclk       (hclk),
    .wr_en      (wr_go),
    .wr_addr    (wr_ptr_ff[AW-1:0]),
    .wr_data    ({core_sym_err, core_sym_err}),
    .rd_en      (rd_go),
    .rd_addr    (rd_ptr_ff[AW-1:0]),
    .rd_data_ff (err_q)
  );

  // ----------------------------------------------------------------
  // MAC-facing receive outputs
  // ----------------------------------------------------------------
  reg       nxt_crs_dv;
  reg [1:0] nxt_rxd;
  reg       nxt_rx_er;

  always @* begin
    nxt_crs_dv = crs_dv;
    nxt_rxd    = rxd;
    nxt_rx_er  = rx_er;
    if (mac_tick) begin
      if (carrier_encode_en) begin
        nxt_crs_dv = rd_vld_ff || (core_carrier && !buf_clear);
      end else begin
        nxt_crs_dv = rd_vld_ff;
      end
      nxt_rxd = rd_vld_ff ? buf_q : 2'h0;
      if (false_carrier_err_en && core_false_carrier) begin
        nxt_rx_er = 1'b1;
      end else begin
        nxt_rx_er = rd_vld_ff && (err_q != 2'h0);
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crs_dv            <= 1'b0;
      rxd               <= 2'h0;
      rx_er             <= 1'b0;
      reduced_if_select <= 1'b0;
    end else begin
      crs_dv            <= nxt_crs_dv;
      rxd               <= nxt_rxd;
      rx_er             <= nxt_rx_er;
      reduced_if_select <= nxt_cfg[`REDUCED_IF_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Transmit frame start watch
  // ----------------------------------------------------------------
  wire tx_act;
  wire tx_sof;

  tx_sof_watch u_sof (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .watch_en     (sof_watch_en),
    .tx_en_s      (tx_s_ff[2]),
    .txd_s        (tx_s_ff[1:0]),
    .tx_active_ff (tx_act),
    .tx_sof_ff    (tx_sof)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_frame_start  <= 1'b0;
      tx_frame_active <= 1'b0;
    end else begin
      tx_frame_start  <= tx_sof;
      tx_frame_active <= tx_act;
    end
  end

endmodule

`default_nettype wire

// ---- sim/rmii_cfg_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmii_cfg_chk #(
  parameter AW = 5
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        core_carrier,
  input wire logic        core_sym_err,
  input wire logic        core_false_carrier,
  input wire logic        mac_tick,
  input wire logic        crs_dv,
  input wire logic        rx_er,
  input wire logic        tx_en,
  input wire logic        tx_frame_start,
  input wire logic        reduced_if_select
);
  // ----------------------------------------------------------------
  // Shadow of the config byte, cycles since a symbol error
  // ----------------------------------------------------------------
  logic [7:0] cfg_ff;
  logic [7:0] quiet_ff;
  logic       wp_ff;
  wire        take = hsel && hready && htrans[1];
  wire        hit  = haddr == 32'h0000ff24;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff   <= 8'h16;
      quiet_ff <= 8'h00;
      wp_ff    <= 1'b0;
    end else begin
      wp_ff    <= take && hwrite && hit && hsize == 3'h2;
      cfg_ff   <= wp_ff ? hwdata[7:0] : cfg_ff;
      quiet_ff <= core_sym_err ? 8'h00 : quiet_ff + {7'h0, quiet_ff != 8'hff};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_miss_zero: assert property (take && !hwrite && !hit |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_read: assert property (take && !hwrite && hit |=> hrdata[31:1] == {24'h01, cfg_ff[7:1]})
    else $error("config read mismatch");
  a_sel_copy: assert property (wp_ff |=> reduced_if_select == $past(hwdata[0]))
    else $error("interface select not following bit 0");
  a_fc_report: assert property (mac_tick && cfg_ff[1] && core_false_carrier |=> rx_er)
    else $error("false carrier not reported");
  a_fc_quiet: assert property (mac_tick && !cfg_ff[1] && quiet_ff == 8'hff |=> !rx_er)
    else $error("receive error without symbol error");
  a_crs_carrier: assert property (mac_tick && cfg_ff[2] && core_carrier |=> crs_dv)
    else $error("carrier not encoded");
  a_clear_idle: assert property (mac_tick && cfg_ff[7] && $past(cfg_ff[7], 4) && !core_carrier
    |=> !crs_dv)
    else $error("data forwarded while buffer held clear");
  a_sof_plain: assert property (!cfg_ff[3] && $rose(tx_en) |-> ##[3:5] tx_frame_start)
    else $error("frame start late on enable");
  a_sof_watch: assert property (cfg_ff[3] && $rose(tx_en) |-> !tx_frame_start [*8])
    else $error("frame start before data seen");
endmodule
bind rmii_mac_port_config rmii_cfg_chk #(.AW(AW)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .core_carrier(core_carrier),
  .core_sym_err(core_sym_err), .core_false_carrier(core_false_carrier),
  .mac_tick(mac_tick), .crs_dv(crs_dv), .rx_er(rx_er), .tx_en(tx_en),
  .tx_frame_start(tx_frame_start), .reduced_if_select(reduced_if_select));
`default_nettype wire

// ---- sim/mac_rmii_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mac_rmii_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       slow,
  input  wire logic       go,
  input  wire logic       crs_dv,
  input  wire logic [1:0] rxd,
  input  wire logic       rx_er,
  output var  logic       mac_tick,
  output var  logic       tx_en,
  output var  logic [1:0] txd
);
  // ----------------------------------------------------------------
  // Output rate tick, one transmit frame per go, receive capture
  // ----------------------------------------------------------------
  logic [2:0] q [$];
  int         cyc;
  int         first;
  int         n;
  logic       t_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc      <= 0;
      n        <= 0;
      t_ff     <= 1'b0;
      mac_tick <= 1'b0;
      tx_en    <= 1'b0;
      txd      <= 2'h0;
    end else begin
      cyc      <= cyc + 1;
      mac_tick <= cyc % (slow ? 3 : 2) == 0;
      t_ff     <= mac_tick;
      n        <= (go || n != 0) && n < 24 ? n + 1 : 0;
      tx_en    <= n > 0 && n < 21;
      // Six idle dibits lead each frame
      txd      <= n > 6 && n < 21 ? 2'(n % 3 + 1) : 2'h0;
      if (t_ff && crs_dv) begin
        first <= q.size() == 0 ? cyc : first;
        q.push_back({rx_er, rxd});
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/test_rmii_mac_port_config.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_rmii_mac_port_config;
  logic        hclk, hresetn, hsel, hwrite, strap, rx_en, rx_dv, carrier, serr, fcar, slow, go;
  logic [1:0]  htrans, rxd_in;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, rd, v;
  wire  [31:0] hrdata;
  wire  [1:0]  rxd, txd;
  wire         hreadyout, hresp, crs_dv, rx_er, sof, act, rsel, tick, tx_en;
  int          fails, cmp_count, t0;
  logic [2:0]  exp_q [$];
  rmii_mac_port_config #(.AW(5)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .strap_reduced_if(strap), .core_rx_en(rx_en), .core_rx_dv(rx_dv), .core_rxd(rxd_in),
    .core_carrier(carrier), .core_sym_err(serr), .core_false_carrier(fcar), .mac_tick(tick),
    .crs_dv(crs_dv), .rxd(rxd), .rx_er(rx_er), .tx_en(tx_en), .txd(txd),
    .tx_frame_start(sof), .tx_frame_active(act), .reduced_if_select(rsel));
  mac_rmii_model mac (.hclk(hclk), .hresetn(hresetn), .slow(slow), .go(go), .crs_dv(crs_dv),
    .rxd(rxd), .rx_er(rx_er), .mac_tick(tick), .tx_en(tx_en), .txd(txd));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int lat(input logic [2:0] c);
    return 4 * int'(c > 3'h5 ? 3'h5 : c) + 5;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rst(input logic s);
    hresetn <= 1'b0;
    strap <= s;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask
  task automatic push(input logic [1:0] d, input logic e);
    @(posedge hclk);
    rx_en <= 1'b1;
    rx_dv <= 1'b1;
    rxd_in <= d;
    serr <= e;
    @(posedge hclk);
    rx_en <= 1'b0;
    serr <= 1'b0;
  endtask
  task automatic frame(input logic [2:0] c);
    logic [2:0] e;
    bus(1, 32'hff24, {25'h0, c, 4'h0}, rd);
    if (c == 3'h5) repeat (6) push(2'h3, 1'b0);
    rx_dv <= 1'b0;
    bus(1, 32'hff24, 32'h80, rd);
    repeat (4) @(posedge hclk);
    bus(1, 32'hff24, {25'h0, c, 4'h0}, rd);
    mac.q.delete();
    exp_q.delete();
    t0 = mac.cyc;
    for (int i = 0; i < 16; i++) begin
      e = {i == 3, 2'($urandom)};
      exp_q.push_back(e);
      push(e[1:0], e[2]);
    end
    rx_dv <= 1'b0;
    repeat (120) @(posedge hclk);
    check(mac.q.size(), 16);
    foreach (exp_q[i]) check(mac.q[i], exp_q[i]);
    check(mac.first - t0 >= lat(c) && mac.first - t0 <= lat(c) + 12, 1);
  endtask
  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    #250000;
    fails++;
    report_and_stop();
  end
  initial begin
    {hresetn, hsel, hwrite, rx_en, rx_dv, carrier, serr, fcar, slow, go} = '0;
    {strap, htrans, rxd_in, hsize, haddr, hwdata} = {1'b1, 4'h0, 3'h2, 64'h0};
    fails = 0;
    cmp_count = 0;
    void'($urandom(46775));
    for (int s = 1; s >= 0; s--) begin
      rst(s[0]);
      bus(0, 32'hff24, 0, rd);
      check(rd, {24'h01, 7'h0b, s[0]});
      check(rsel, s[0]);
    end
    bus(1, 32'hff28, 32'hff, rd);
    bus(0, 32'hff28, 0, rd);
    check(rd, 0);
    bus(0, 32'hff24, 0, rd);
    check(rd, 32'h116);
    repeat (20) begin
      v = $urandom & 32'hffff_fffe;
      bus(1, 32'hff24, v, rd);
      bus(0, 32'hff24, 0, rd);
      check(rd, {24'h01, v[7:0]});
    end
    repeat (200) @(posedge hclk);
    for (int b = 0; b < 2; b++) begin
      bus(1, 32'hff24, {29'h0, b[0], b[0], 1'b0}, rd);
      carrier <= 1'b1;
      fcar <= 1'b1;
      repeat (8) @(posedge hclk);
      check(crs_dv, b[0]);
      check(rx_er, b[0]);
      carrier <= 1'b0;
      fcar <= 1'b0;
    end
    for (int c = 0; c < 7; c++) begin
      slow <= c[0];
      frame(c[2:0]);
    end
    for (int b = 0; b < 2; b++) begin
      bus(1, 32'hff24, {28'h0, b[0], 3'h0}, rd);
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      t0 = 0;
      repeat (15) begin
        @(posedge hclk);
        t0 += int'(sof);
      end
      check(act, 1'b1);
      repeat (20) begin
        @(posedge hclk);
        t0 += int'(sof);
      end
      check(act, 1'b0);
      check(t0, 1);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
